// ### core/scp_device.sv
// What this block does
// - Instruction bit 7 high reads, low writes
// - Count field gives one to four bytes
// - Low five bits address, decremented per byte
// - All bytes travel most significant bit first
// - Host holds frame enable low whole frame
// - First byte instruction, then data bytes
// - Device captures bits on rising serial clock
// - Device launches read bits on falling edge
// - Three or four wire mode by configuration
// - Three wire: data pin reads, alarm pin shows clock alarm except in read data phase
// - Four wire: both pins carry read data
// - Four wire: alarm pin low after read until frame end
// - Gain words eleven bits, reset to unity
// - Gain A low write loads all settings
// - Host writes gain A low byte last
// - Phase word ten bits signed, reset zero
// - Phase times Q added into I sample
// - Upper register packs phase and gain tops
// - Clock alarm sets after four stopped cycles
// - Alarm sets transmit off, forcing mid-level
// - Version bits hardwired and read only
// - Four wire turns alarm pin into data
`timescale 1ns/10ps
module scp_device
  import scp_pkg::*;
#(
  parameter logic [5:0] VERSION_CODE = 6'h2a,
  parameter int STOP_CYCLES = DCLK_STOP_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  scp_if.dev link,
  input wire logic data_interface_clock,
  input wire logic four_wire_enable,
  input wire logic [15:0] sample_i,
  input wire logic [15:0] sample_q,
  output logic [10:0] gain_a_active_r,
  output logic [10:0] gain_b_active_r,
  output logic [9:0] phase_active_r,
  output logic clk_alarm_r,
  output logic tx_off_r,
  output logic [15:0] corr_i_r,
  output logic [15:0] corr_q_r
);
  // Version value is arbitrary
  localparam int SW = $clog2(STOP_CYCLES + 1);

  logic [1:0] sclk_s;
  logic [1:0] fen_s;
  logic [1:0] sdi_s;
  logic [1:0] dclk_s;
  logic sclk_q;
  logic dclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic in_frame;
  scp_dev_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shin_r;
  logic [7:0] shin_nxt;
  logic [7:0] shout_r;
  logic rw_r;
  logic [1:0] bytes_left_r;
  logic [4:0] addr_r;
  logic byte_done;
  logic wr_en;
  logic post_r;
  logic [7:0] gain_a_low_r;
  logic [7:0] gain_b_low_r;
  logic [7:0] phase_low_r;
  logic [7:0] upper_r;
  logic [SW-1:0] stop_cnt_r;
  logic alarm_set;
  logic dclk_edge;
  logic signed [25:0] prod;
  logic [16:0] sum;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_s <= 2'h0;
      fen_s <= 2'h3;
      sdi_s <= 2'h0;
      dclk_s <= 2'h0;
      sclk_q <= 1'b0;
      dclk_q <= 1'b0;
    end
    else
    begin
      sclk_s <= {sclk_s[0], link.sclk};
      fen_s <= {fen_s[0], link.frame_enable_n};
      sdi_s <= {sdi_s[0], link.sdio_line};
      dclk_s <= {dclk_s[0], data_interface_clock};
      sclk_q <= sclk_s[1];
      dclk_q <= dclk_s[1];
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_q;
  assign sclk_fall = ~sclk_s[1] & sclk_q;
  assign in_frame = ~fen_s[1];
  assign shin_nxt = {shin_r[6:0], sdi_s[1]};
  assign byte_done = sclk_rise & in_frame & (bit_cnt_r == 3'h7);
  assign wr_en = byte_done & (state_r == SCP_D_DATA) & ~rw_r;

  function automatic logic [7:0] rd_mux(input logic [4:0] a);
    case (a)
      ADDR_GAIN_A_LOW: rd_mux = gain_a_low_r;
      ADDR_GAIN_B_LOW: rd_mux = gain_b_low_r;
      ADDR_PHASE_LOW: rd_mux = phase_low_r;
      ADDR_GAIN_PHASE_UPPER: rd_mux = upper_r;
      ADDR_ALARM_VERSION: rd_mux = {clk_alarm_r, tx_off_r, VERSION_CODE};
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // ****************************************
  // Frame decoder
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SCP_D_INSTR;
      bit_cnt_r <= 3'h0;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      rw_r <= 1'b0;
      bytes_left_r <= 2'h0;
      addr_r <= 5'h00;
    end
    else if (!in_frame)
    begin
      state_r <= SCP_D_INSTR;
      bit_cnt_r <= 3'h0;
    end
    else if (sclk_rise && state_r != SCP_D_DONE)
    begin
      shin_r <= shin_nxt;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done)
      begin
        case (state_r)
          SCP_D_INSTR:
          begin
            rw_r <= shin_nxt[7];
            bytes_left_r <= shin_nxt[6:5];
            addr_r <= shin_nxt[4:0];
            shout_r <= rd_mux(shin_nxt[4:0]);
            state_r <= SCP_D_DATA;
          end
          SCP_D_DATA:
          begin
            addr_r <= addr_r - 5'h01;
            shout_r <= rd_mux(addr_r - 5'h01);
            if (bytes_left_r == 2'h0)
            begin
              state_r <= SCP_D_DONE;
            end
            else
            begin
              bytes_left_r <= bytes_left_r - 2'h1;
            end
          end
          default:
          begin
            state_r <= SCP_D_DONE;
          end
        endcase
      end
    end
    else if (sclk_fall && rw_r && state_r == SCP_D_DATA)
    begin
      shout_r <= {shout_r[6:0], 1'b0};
    end
  end

  // ****************************************
  // Read data drivers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.sdio_dev_o <= 1'b0;
      link.sdio_dev_oe <= 1'b0;
      post_r <= 1'b0;
    end
    else if (!in_frame)
    begin
      link.sdio_dev_oe <= 1'b0;
      post_r <= 1'b0;
    end
    else if (sclk_fall && rw_r && state_r == SCP_D_DATA)
    begin
      link.sdio_dev_o <= shout_r[7];
      link.sdio_dev_oe <= 1'b1;
    end
    else if (sclk_fall && rw_r && state_r == SCP_D_DONE && link.sdio_dev_oe)
    begin
      link.sdio_dev_oe <= 1'b0;
      post_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.alarm_o <= 1'b0;
      link.alarm_oe <= 1'b0;
    end
    else if (four_wire_enable)
    begin
      link.alarm_o <= post_r ? 1'b0 : link.sdio_dev_o;
      link.alarm_oe <= link.sdio_dev_oe | post_r;
    end
    else
    begin
      link.alarm_o <= clk_alarm_r;
      link.alarm_oe <= ~(in_frame & rw_r & state_r != SCP_D_INSTR);
    end
  end

  // ****************************************
  // Correction registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_a_low_r <= LOW_RST;
      gain_b_low_r <= LOW_RST;
      phase_low_r <= LOW_RST;
      upper_r <= UPPER_RST;
    end
    else if (wr_en)
    begin
      case (addr_r)
        ADDR_GAIN_A_LOW: gain_a_low_r <= shin_nxt;
        ADDR_GAIN_B_LOW: gain_b_low_r <= shin_nxt;
        ADDR_PHASE_LOW: phase_low_r <= shin_nxt;
        ADDR_GAIN_PHASE_UPPER: upper_r <= shin_nxt;
        default: upper_r <= upper_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_a_active_r <= GAIN_ACTIVE_RST;
      gain_b_active_r <= GAIN_ACTIVE_RST;
      phase_active_r <= PHASE_ACTIVE_RST;
    end
    else if (wr_en && addr_r == ADDR_GAIN_A_LOW)
    begin
      gain_a_active_r <= {upper_r[5:3], shin_nxt};
      gain_b_active_r <= {upper_r[2:0], gain_b_low_r};
      phase_active_r <= {upper_r[7:6], phase_low_r};
    end
  end

  // ****************************************
  // Data clock watchdog and alarm flags
  // ****************************************
  assign dclk_edge = dclk_s[1] ^ dclk_q;
  assign alarm_set = ~dclk_edge & (stop_cnt_r == SW'(STOP_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_cnt_r <= '0;
    end
    else if (dclk_edge)
    begin
      stop_cnt_r <= '0;
    end
    else if (stop_cnt_r != SW'(STOP_CYCLES))
    begin
      stop_cnt_r <= stop_cnt_r + SW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_alarm_r <= 1'b0;
      tx_off_r <= 1'b0;
    end
    else
    begin
      if (alarm_set)
      begin
        clk_alarm_r <= 1'b1;
        tx_off_r <= 1'b1;
      end
      else if (wr_en && addr_r == ADDR_ALARM_VERSION)
      begin
        clk_alarm_r <= clk_alarm_r & shin_nxt[CLK_ALARM_BIT];
        tx_off_r <= tx_off_r & shin_nxt[TX_OFF_BIT];
      end
    end
  end

  // ****************************************
  // Phase correction datapath
  // ****************************************
  assign prod = $signed(phase_active_r) * $signed(sample_q);
  assign sum = {sample_i[15], sample_i} + {{3{prod[25]}}, prod[25:PHASE_FRAC_BITS]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      corr_i_r <= 16'h0000;
      corr_q_r <= 16'h0000;
    end
    else if (tx_off_r)
    begin
      corr_i_r <= 16'h0000;
      corr_q_r <= 16'h0000;
    end
    else
    begin
      corr_i_r <= sum[15:0];
      corr_q_r <= sample_q;
    end
  end

endmodule : scp_device

// ### core/scp_host.sv
`timescale 1ns/10ps
module scp_host
  import scp_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  scp_if.host link
);
  scp_host_state_type state_r;
  logic [7:0] instr_r;
  logic four_wire_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [39:0] tx_r;
  logic [31:0] rx_r;
  logic [7:0] half_r;
  logic [5:0] bit_r;
  logic [5:0] last_bit;
  logic [1:0] sdi_s;
  logic [1:0] alm_s;
  logic acc;
  logic go;
  logic mapped;

  assign acc = psel & penable & pready_r;
  assign go = acc & pwrite & (paddr == HOST_CTRL) & pwdata[CTRL_GO_BIT] & (state_r == SCP_H_IDLE);
  assign mapped = (paddr == HOST_CTRL) | (paddr == HOST_WDATA) | (paddr == HOST_STATUS) | (paddr == HOST_RDATA);
  assign last_bit = {1'b0, instr_r[6:5], 3'h7} + 6'h08;

  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      case (paddr)
        HOST_CTRL: prdata_r <= {22'h0, four_wire_r, 1'b0, instr_r};
        HOST_WDATA: prdata_r <= wdata_r;
        HOST_STATUS: prdata_r <= {31'h0, state_r != SCP_H_IDLE};
        HOST_RDATA: prdata_r <= rdata_r;
        default: prdata_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_r <= 8'h00;
      four_wire_r <= 1'b0;
      wdata_r <= 32'h00000000;
    end
    else if (acc && pwrite && state_r == SCP_H_IDLE)
    begin
      if (paddr == HOST_CTRL)
      begin
        instr_r <= pwdata[7:0];
        four_wire_r <= pwdata[CTRL_FOUR_WIRE_BIT];
      end
      if (paddr == HOST_WDATA)
      begin
        wdata_r <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sdi_s <= 2'h0;
      alm_s <= 2'h0;
    end
    else
    begin
      sdi_s <= {sdi_s[0], link.sdio_line};
      alm_s <= {alm_s[0], link.alarm_line};
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SCP_H_IDLE;
      link.sclk <= 1'b0;
      link.frame_enable_n <= 1'b1;
      link.sdio_host_o <= 1'b0;
      link.sdio_host_oe <= 1'b0;
      tx_r <= 40'h0000000000;
      rx_r <= 32'h00000000;
      rdata_r <= 32'h00000000;
      half_r <= 8'h00;
      bit_r <= 6'h00;
    end
    else
    begin
      half_r <= (half_r == 8'(HALF - 1)) ? 8'h00 : half_r + 8'h01;
      case (state_r)
        SCP_H_IDLE:
        begin
          half_r <= 8'h00;
          if (go)
          begin
            tx_r <= {pwdata[7:0], wdata_r};
            link.sdio_host_o <= pwdata[7];
            link.sdio_host_oe <= 1'b1;
            link.frame_enable_n <= 1'b0;
            bit_r <= 6'h00;
            state_r <= SCP_H_LEAD;
          end
        end
        SCP_H_LEAD:
        begin
          if (half_r == 8'(HALF - 1))
          begin
            state_r <= SCP_H_RUN;
          end
        end
        SCP_H_RUN:
        begin
          if (half_r == 8'(HALF - 1))
          begin
            link.sclk <= ~link.sclk;
            if (!link.sclk && instr_r[7] && bit_r > 6'h07)
            begin
              rx_r <= {rx_r[30:0], four_wire_r ? alm_s[1] : sdi_s[1]};
            end
            if (link.sclk)
            begin
              bit_r <= bit_r + 6'h01;
              tx_r <= {tx_r[38:0], 1'b0};
              link.sdio_host_o <= tx_r[38];
              link.sdio_host_oe <= ~(instr_r[7] && bit_r >= 6'h07) && bit_r != last_bit;
              if (bit_r == last_bit)
              begin
                state_r <= SCP_H_TAIL;
              end
            end
          end
        end
        SCP_H_TAIL:
        begin
          if (half_r == 8'(HALF - 1))
          begin
            link.frame_enable_n <= 1'b1;
            rdata_r <= rx_r;
            state_r <= SCP_H_IDLE;
          end
        end
        default:
        begin
          state_r <= SCP_H_IDLE;
        end
      endcase
    end
  end

endmodule : scp_host

// ### core/scp_if.sv
`timescale 1ns/10ps
interface scp_if;
  logic sclk;
  logic frame_enable_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic alarm_o;
  logic alarm_oe;
  logic sdio_line;
  logic alarm_line;

  // ****************************************
  // Wire levels, pulled high when undriven
  // ****************************************
  assign sdio_line = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
  assign alarm_line = alarm_oe ? alarm_o : 1'b1;

  modport host (output sclk, output frame_enable_n, output sdio_host_o, output sdio_host_oe,
                input sdio_line, input alarm_line);
  modport dev (input sclk, input frame_enable_n, input sdio_line, output sdio_dev_o,
               output sdio_dev_oe, output alarm_o, output alarm_oe);
endinterface : scp_if

// ### core/scp_pkg.sv
package scp_pkg;

  // ****************************************
  // Register map of the device
  // ****************************************
  localparam logic [4:0] ADDR_GAIN_A_LOW = 5'h1b;
  localparam logic [4:0] ADDR_GAIN_B_LOW = 5'h1c;
  localparam logic [4:0] ADDR_PHASE_LOW = 5'h1d;
  localparam logic [4:0] ADDR_GAIN_PHASE_UPPER = 5'h1e;
  localparam logic [4:0] ADDR_ALARM_VERSION = 5'h1f;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'h24;
  localparam logic [10:0] GAIN_ACTIVE_RST = 11'h400;
  localparam logic [9:0] PHASE_ACTIVE_RST = 10'h000;
  localparam int CLK_ALARM_BIT = 7;
  localparam int TX_OFF_BIT = 6;
  localparam int PHASE_FRAC_BITS = 12;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PCLK_PERIOD_NS = 5;
  localparam int DCLK_PERIOD_NS = 160;
  localparam int DCLK_STOP_PERIODS = 4;
  localparam int DCLK_STOP_CYCLES = (DCLK_STOP_PERIODS * DCLK_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

  // ****************************************
  // Host command registers
  // ****************************************
  localparam logic [7:0] HOST_CTRL = 8'h00;
  localparam logic [7:0] HOST_WDATA = 8'h04;
  localparam logic [7:0] HOST_STATUS = 8'h08;
  localparam logic [7:0] HOST_RDATA = 8'h0c;
  localparam int CTRL_GO_BIT = 8;
  localparam int CTRL_FOUR_WIRE_BIT = 9;

  typedef enum logic [1:0] {
    SCP_D_INSTR = 2'b00,
    SCP_D_DATA = 2'b01,
    SCP_D_DONE = 2'b11
  } scp_dev_state_type;

  typedef enum logic [1:0] {
    SCP_H_IDLE = 2'b00,
    SCP_H_LEAD = 2'b01,
    SCP_H_RUN = 2'b11,
    SCP_H_TAIL = 2'b10
  } scp_host_state_type;

endpackage : scp_pkg

// ### dv/scp_sva.sv
`timescale 1ns/10ps
module scp_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic frame_enable_n,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_o,
  input wire logic sdio_dev_oe,
  input wire logic alarm_o,
  input wire logic alarm_oe,
  input wire logic sdio_line,
  input wire logic alarm_line
);
  // ********
  // Rising serial clock count per frame
  // ********
  logic sclk_q_r;
  logic [5:0] rise_cnt_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_q_r <= 1'b0;
      rise_cnt_r <= 6'h00;
    end
    else
    begin
      sclk_q_r <= sclk;
      if (frame_enable_n)
        rise_cnt_r <= 6'h00;
      else if (sclk && !sclk_q_r)
        rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ********
  // Link checks
  // ********
  AST_FRAME_BITS: assert property ($rose(frame_enable_n) |-> rise_cnt_r inside {6'd16, 6'd24, 6'd32, 6'd40})
    else $error("Frame bit count not whole bytes");
  AST_INSTR_QUIET: assert property (sdio_dev_oe |-> rise_cnt_r >= 6'd8)
    else $error("Device drives during instruction");
  AST_SCLK_IN_FRAME: assert property (sclk |-> !frame_enable_n)
    else $error("Serial clock high outside frame");
  AST_NO_CONTENTION: assert property (!(sdio_host_oe && sdio_dev_oe))
    else $error("Both ends drive data pin");
  AST_RELEASE_AFTER: assert property (frame_enable_n && $past(frame_enable_n, 4) |-> !sdio_dev_oe)
    else $error("Device drives data pin between frames");
  AST_LAUNCH_LOW: assert property (sdio_dev_oe && $changed(sdio_dev_o) |-> !sclk)
    else $error("Read bit launched while clock high");
  AST_HOST_HOLD: assert property (sdio_host_oe && sclk |-> $stable(sdio_host_o))
    else $error("Host data moved while clock high");
  AST_MIRROR: assert property (alarm_oe && sdio_dev_oe |-> alarm_o == $past(sdio_dev_o))
    else $error("Alarm pin does not follow read data");
  AST_POST_READ_LOW: assert property ($fell(sdio_dev_oe) |-> ##2 (!alarm_oe || !alarm_o))
    else $error("Alarm pin not low after read");

  cover property ($rose(frame_enable_n) && rise_cnt_r == 6'd40);
  cover property (alarm_oe && sdio_dev_oe);
  cover property ($fell(sdio_dev_oe));
endmodule : scp_sva

// ### dv/serial_ctrl_port_iq_corr_regs_tb.sv
`timescale 1ns/10ps
module serial_ctrl_port_iq_corr_regs_tb
  import scp_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready_r, pslverr_r, er;
  logic [7:0] paddr, wire_sh, wire_instr;
  logic [31:0] pwdata, prdata_r, rd;
  logic dclk, dclk_run, four_wire_enable, clk_alarm_r, tx_off_r;
  logic [15:0] sample_i, sample_q, corr_i_r, corr_q_r;
  logic [10:0] gain_a_active_r, gain_b_active_r;
  logic [9:0] phase_active_r;
  int wire_n;
  int n_mismatch = 0;
  int n_compared = 0;

  // ********
  // Ends and checker
  // ********
  scp_if u_scp_if();
  scp_host #(.HALF(8)) u_scp_host(.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .link(u_scp_if));
  // Version value arbitrary
  scp_device #(.VERSION_CODE(6'h15)) u_scp_device(.pclk(pclk), .presetn(presetn),
    .link(u_scp_if), .data_interface_clock(dclk), .four_wire_enable(four_wire_enable),
    .sample_i(sample_i), .sample_q(sample_q), .gain_a_active_r(gain_a_active_r),
    .gain_b_active_r(gain_b_active_r), .phase_active_r(phase_active_r), .clk_alarm_r(clk_alarm_r),
    .tx_off_r(tx_off_r), .corr_i_r(corr_i_r), .corr_q_r(corr_q_r));
  scp_sva u_scp_sva(.pclk(pclk), .presetn(presetn), .sclk(u_scp_if.sclk),
    .frame_enable_n(u_scp_if.frame_enable_n), .sdio_host_o(u_scp_if.sdio_host_o),
    .sdio_host_oe(u_scp_if.sdio_host_oe), .sdio_dev_o(u_scp_if.sdio_dev_o),
    .sdio_dev_oe(u_scp_if.sdio_dev_oe), .alarm_o(u_scp_if.alarm_o), .alarm_oe(u_scp_if.alarm_oe),
    .sdio_line(u_scp_if.sdio_line), .alarm_line(u_scp_if.alarm_line));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    dclk = 1'b0;
    #37;
    forever #80 dclk = dclk_run ? ~dclk : dclk;
  end

  // Instruction byte as seen on the wire
  always @(posedge u_scp_if.sclk or posedge u_scp_if.frame_enable_n)
  begin
    if (u_scp_if.frame_enable_n)
      wire_n <= 0;
    else
    begin
      wire_sh <= {wire_sh[6:0], u_scp_if.sdio_line};
      wire_n <= wire_n + 1;
      if (wire_n == 7)
        wire_instr <= {wire_sh[6:0], u_scp_if.sdio_line};
    end
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic close_out();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic give_up(input string nm);
    n_mismatch++;
    $display("[FAIL] %s expected done seen timeout", nm);
    close_out();
  endtask : give_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready_r !== 1'b1 && i < 50);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
      give_up("pready");
  endtask : apb

  task automatic ser(input logic [9:0] ctl, input logic [31:0] wd);
    int i;
    apb(1'b1, HOST_WDATA, wd);
    apb(1'b1, HOST_CTRL, {22'h0, ctl[9], 1'b1, ctl[7:0]});
    i = 0;
    do
    begin
      apb(1'b0, HOST_STATUS, 32'h0);
      i++;
    end
    while (rd[0] !== 1'b0 && i < 500);
    if (i >= 500)
      give_up("busy");
    chk("wire instr", {24'h0, ctl[7:0]}, {24'h0, wire_instr});
    apb(1'b0, HOST_RDATA, 32'h0);
  endtask : ser

  // ********
  // Main sequence
  // ********
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dclk_run = 1'b1;
    four_wire_enable = 1'b0;
    sample_i = 16'h1000;
    sample_q = 16'h2000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("gain a rst", 32'h400, 32'(gain_a_active_r));
    chk("phase rst", 32'h0, 32'(phase_active_r));
    ser(10'h0ff, 32'h0);
    chk("read 1f to 1c", 32'h1524_0000, rd);
    ser(10'h05e, 32'h5b80_3300);
    apb(1'b0, HOST_WDATA, 32'h0);
    chk("wdata back", 32'h5b80_3300, rd);
    chk("gain a held", 32'h400, 32'(gain_a_active_r));
    chk("phase held", 32'h0, 32'(phase_active_r));
    ser(10'h01b, 32'hc500_0000);
    chk("gain a", 32'h3c5, 32'(gain_a_active_r));
    chk("gain b", 32'h333, 32'(gain_b_active_r));
    chk("phase", 32'h180, 32'(phase_active_r));
    chk("corr i", 32'h1300, 32'(corr_i_r));
    chk("corr q", 32'h2000, 32'(corr_q_r));
    for (int m = 0; m < 2; m++)
    begin
      four_wire_enable <= m[0];
      ser({m[0], 9'h0be}, 32'h0);
      chk("read 1e 1d", 32'h5b80, {16'h0, rd[15:0]});
      ser({m[0], 9'h09c}, 32'h0);
      chk("read 1c", 32'h33, {24'h0, rd[7:0]});
    end
    apb(1'b0, HOST_CTRL, 32'h0);
    chk("ctrl back", 32'h29c, rd);
    four_wire_enable <= 1'b0;
    ser(10'h085, 32'h0);
    chk("unmapped reg", 32'h0, {24'h0, rd[7:0]});
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    dclk_run <= 1'b0;
    repeat (100) @(posedge pclk);
    chk("alarm early", 32'h0, {31'h0, clk_alarm_r});
    chk("tx off early", 32'h0, {31'h0, tx_off_r});
    repeat (100) @(posedge pclk);
    chk("alarm", 32'h1, {31'h0, clk_alarm_r});
    chk("tx off", 32'h1, {31'h0, tx_off_r});
    chk("corr i off", 32'h0, 32'(corr_i_r));
    chk("corr q off", 32'h0, 32'(corr_q_r));
    dclk_run <= 1'b1;
    ser(10'h09f, 32'h0);
    chk("flags set", 32'hd5, {24'h0, rd[7:0]});
    ser(10'h01f, 32'hff00_0000);
    ser(10'h09f, 32'h0);
    chk("version kept", 32'hd5, {24'h0, rd[7:0]});
    ser(10'h01f, 32'h0);
    ser(10'h09f, 32'h0);
    chk("flags clear", 32'h15, {24'h0, rd[7:0]});
    chk("tx off clear", 32'h0, {31'h0, tx_off_r});
    close_out();
  end
endmodule : serial_ctrl_port_iq_corr_regs_tb
